//--- inc/rfs_regs.svh
// Register offsets, field positions, reset values and timing figures
// Definitions only; included by the reset sequencer design files
`ifndef RFS_REGS_SVH
`define RFS_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RFS_OFF_MAIN_RESET_FLAG_REGISTER   8'h00
`define RFS_OFF_SUP    8'h04
`define RFS_OFF_OSC    8'h08
`define RFS_OFF_CTL    8'h0c
`define RFS_OFF_CAL    8'h10
`define RFS_OFF_NVM    8'h14

// ----------------------------------------
// Masks and reset values
// ----------------------------------------
`define RFS_MAIN_RESET_FLAG_REGISTER_MASK  16'hd7ff
`define RFS_MAIN_RESET_FLAG_REGISTER_POR   16'h0003
`define RFS_SUP_MASK   16'h000f
`define RFS_SUP_POR    16'h000e
`define RFS_CAL_POR    16'h0000
`define RFS_NVM_POR    16'h0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RFS_B_POR      0
`define RFS_B_BOR      1
`define RFS_B_IDLE     2
`define RFS_B_SLEEP    3
`define RFS_B_WATCHDOG_TIMEOUT_FLAG     4
`define RFS_B_DEEP_SLEEP_FLAG    10
`define RFS_B_SUPBOR   3
`define RFS_B_SUPPOR   2
`define RFS_B_BATTERY_POWERON_FLAG    1
`define RFS_B_VBAT     0

// ----------------------------------------
// Oscillator select codes and timing
// ----------------------------------------
`define RFS_OSC_FRC    3'h0
`define RFS_OSC_FRCPLL 3'h1
`define RFS_OSC_PRI    3'h2
`define RFS_OSC_PRIPLL 3'h3
`define RFS_OSC_SOSC   3'h4
`define RFS_OSC_LOW_POWER_INTERNAL_RC   3'h5
`define RFS_OSC_FRCDIV 3'h7
`define RFS_CLK_MHZ    125
`define RFS_POWERON_DELAY_US    10
`define RFS_TRST_US    2
`define RFS_OST_LAST   10'h3ff

`endif

//--- inc/rfs_pkg.sv
// Types shared by the reset flag and release sequencer
// Assumes rfs_regs.svh carries all numeric constants
`default_nettype none

package rfs_pkg;

   typedef enum logic [1:0] {SEQ_RUN, SEQ_HOLD} rfs_seq_e;
   typedef enum logic [1:0] {RK_POR, RK_BOR, RK_SHORT} rfs_kind_e;
   typedef enum logic [1:0] {CK_IDLE, CK_WAIT, CK_FRC} rfs_ck_e;

   // Same-clock reset and instruction event pulses
   typedef struct packed {
      logic trap;
      logic illop;
      logic cfgmis;
      logic swrst;
      logic wdt_to;
      logic wdt_clr;
      logic power_save_instruction;
      logic power_save_instruction_op;
   } rfs_evt_s;

   // Static configuration word fields
   typedef struct packed {
      logic [2:0] osc_sel;
      logic       pri_xtal;
      logic       clk_sw_en;
      logic       bor_en;
      logic       two_speed;
      logic       clock_fail_monitor_en;
   } rfs_cfg_s;

   // Asynchronous detector and oscillator pins
   typedef struct packed {
      logic por;
      logic bor;
      logic batt_ok;
      logic ext_rst_n;
      logic osc_clk;
      logic pll_lock;
   } rfs_pin_s;

endpackage

`default_nettype wire

//--- verilog/rfs_top.sv
// Reset flags, reset release sequencing and clock source choice at reset
// Assumes pclk runs free from power-up; pins are asynchronous to pclk
`timescale 1ns/1ps
`default_nettype none
`include "rfs_regs.svh"

module rfs_top
#(
   parameter int TVREG_NS = 10000,  // Regulator start-up time
   parameter int TFRC_NS  = 1000,   // Fast RC start-up time
   parameter int TLPRC_NS = 2000,   // Low-power RC start-up time
   parameter int TFSCM_NS = 1000,   // Monitor start delay after release
   parameter int CW       = 16      // Delay counter width
)
(
   input  wire logic               pclk,                // Bus clock, free running
   input  wire logic               presetn,             // Power-on reset, active low
   input  wire logic               clk_en,              // Freezes all state when low
   input  wire logic               psel,                // APB select
   input  wire logic               penable,             // APB enable
   input  wire logic               pwrite,              // APB write
   input  wire logic [7:0]         paddr,               // APB byte address
   input  wire logic [31:0]        pwdata,              // APB write data
   output var  logic [31:0]        prdata,              // APB read data
   output var  logic               pready,              // APB ready
   output var  logic               pslverr,             // APB error, unmapped
   input  wire rfs_pkg::rfs_pin_s  pins,                // Asynchronous pins
   input  wire rfs_pkg::rfs_evt_s  evt,                 // Event pulses
   input  wire rfs_pkg::rfs_cfg_s  cfg,                 // Configuration fields
   output var  logic               master_reset_signal, // Master reset, high active
   output var  logic [2:0]         sys_clk_src,         // Released clock source
   output var  logic               sys_clk_ok,          // System clock released
   output var  logic               clock_fail_monitor_active          // Clock monitor running
);
   import rfs_pkg::*;

   // ----------------------------------------
   // Delay counts
   // ----------------------------------------
   localparam int POR_I  = `RFS_POWERON_DELAY_US * `RFS_CLK_MHZ;
   localparam int RST_I  = `RFS_TRST_US * `RFS_CLK_MHZ;
   localparam int VREG_I = (TVREG_NS * `RFS_CLK_MHZ + 999) / 1000;
   localparam logic [CW-1:0] CYC_POR  = CW'(POR_I + VREG_I + RST_I);
   localparam logic [CW-1:0] CYC_BOR  = CW'(VREG_I + RST_I);
   localparam logic [CW-1:0] CYC_RST  = CW'(RST_I);
   localparam logic [CW-1:0] CYC_FRC  = CW'((TFRC_NS * `RFS_CLK_MHZ + 999) / 1000);
   localparam logic [CW-1:0] CYC_LOW_POWER_INTERNAL_RC = CW'((TLPRC_NS * `RFS_CLK_MHZ + 999) / 1000);
   localparam logic [CW-1:0] CYC_CLOCK_FAIL_MONITOR = CW'((TFSCM_NS * `RFS_CLK_MHZ + 999) / 1000);
   localparam logic [CW-1:0] CNT_MAX  = '1;

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   function automatic logic is_pll(input logic [2:0] s);
      is_pll = (s == `RFS_OSC_FRCPLL) | (s == `RFS_OSC_PRIPLL);
   endfunction

   function automatic logic is_xtal(input logic [2:0] s, input logic x);
      is_xtal = (((s == `RFS_OSC_PRI) | (s == `RFS_OSC_PRIPLL)) & x) | (s == `RFS_OSC_SOSC);
   endfunction

   function automatic logic is_frc(input logic [2:0] s);
      is_frc = (s == `RFS_OSC_FRC) | (s == `RFS_OSC_FRCPLL) | (s == `RFS_OSC_FRCDIV);
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [5:0] pin_meta;
   logic [5:0] pin_sync;
   logic [5:0] pin_prev;
   rfs_pin_s   ps;
   rfs_pin_s   pp;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_meta <= 6'h04;
         pin_sync <= 6'h04;
         pin_prev <= 6'h24;
      end
      else if (clk_en)
      begin
         pin_meta <= pins;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   assign ps = pin_sync;
   assign pp = pin_prev;

   // ----------------------------------------
   // Reset events
   // ----------------------------------------
   wire por_evt   = ps.por & ~pp.por;
   wire bor_evt   = ps.bor & ~pp.bor & cfg.bor_en & ~por_evt;
   wire ext_evt   = ~ps.ext_rst_n & pp.ext_rst_n;
   wire osc_tick  = ps.osc_clk & ~pp.osc_clk;
   wire short_src = ext_evt | evt.trap | evt.illop | evt.cfgmis | evt.swrst | evt.wdt_to;
   wire short_evt = short_src & ~por_evt & ~bor_evt;
   wire any_evt   = por_evt | bor_evt | short_evt;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   wire setup    = psel & ~penable;
   wire wr       = psel & penable & pwrite & pready;
   wire wr_main_reset_flag_register  = wr & hit(paddr, `RFS_OFF_MAIN_RESET_FLAG_REGISTER);
   wire wr_sup   = wr & hit(paddr, `RFS_OFF_SUP);
   wire wr_ctl   = wr & hit(paddr, `RFS_OFF_CTL);
   wire wr_cal   = wr & hit(paddr, `RFS_OFF_CAL);
   wire wr_nvm   = wr & hit(paddr, `RFS_OFF_NVM);

   // ----------------------------------------
   // Flag registers
   // ----------------------------------------
   logic [15:0] main_reset_flag_register;
   logic [15:0] sup;
   logic [15:0] cal;
   logic [15:0] nvm;
   logic        deep_sleep_enable;
   rfs_seq_e    seq_st;
   rfs_kind_e   kind;
   logic [CW-1:0] seq_cnt;

   wire slp_set  = evt.power_save_instruction & ~evt.power_save_instruction_op;
   wire dslp_set = slp_set & deep_sleep_enable;
   wire idl_set  = evt.power_save_instruction & evt.power_save_instruction_op;
   wire rel      = (seq_st == SEQ_HOLD) & (seq_cnt == CW'(1)) & ~any_evt;
   wire vbat_set = rel & (kind == RK_POR) & ps.batt_ok;

   // Set terms win over the software and watchdog clear terms
   wire [15:0] main_reset_flag_register_set = {evt.trap, evt.illop, 3'b000, dslp_set, evt.cfgmis, 1'b0,
                           ext_evt, evt.swrst, 1'b0, evt.wdt_to, slp_set, idl_set,
                           bor_evt, 1'b0};
   wire [15:0] main_reset_flag_register_clr = {11'h000, evt.wdt_clr | evt.power_save_instruction, 4'h0};
   wire [15:0] main_reset_flag_register_wr  = wr_main_reset_flag_register ? pwdata[15:0] : main_reset_flag_register;
   wire [15:0] next_main_reset_flag_register = por_evt ? `RFS_MAIN_RESET_FLAG_REGISTER_POR
                                   : (((main_reset_flag_register_wr & ~main_reset_flag_register_clr) | main_reset_flag_register_set) & `RFS_MAIN_RESET_FLAG_REGISTER_MASK);
   wire [15:0] sup_set  = {12'h000, bor_evt, por_evt, ~ps.batt_ok, vbat_set};
   wire [15:0] sup_wr   = wr_sup ? (sup & pwdata[15:0]) : sup;
   wire [15:0] next_sup = (sup_wr | sup_set) & `RFS_SUP_MASK;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         main_reset_flag_register <= `RFS_MAIN_RESET_FLAG_REGISTER_POR;
         sup  <= `RFS_SUP_POR;
      end
      else if (clk_en)
      begin
         main_reset_flag_register <= next_main_reset_flag_register;
         sup  <= next_sup;
      end
   end

   // Calibration and nonvolatile control survive all but power-on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cal <= `RFS_CAL_POR;
         nvm <= `RFS_NVM_POR;
      end
      else if (clk_en)
      begin
         cal <= por_evt ? `RFS_CAL_POR : (wr_cal ? pwdata[15:0] : cal);
         nvm <= por_evt ? `RFS_NVM_POR : (wr_nvm ? pwdata[15:0] : nvm);
      end
   end

   // Control register takes one value under every reset type
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         deep_sleep_enable <= 1'b0;
      else if (clk_en)
         deep_sleep_enable <= master_reset_signal ? 1'b0 : (wr_ctl ? pwdata[0] : deep_sleep_enable);
   end

   // ----------------------------------------
   // Master reset sequencer
   // ----------------------------------------
   rfs_seq_e      next_seq_st;
   rfs_kind_e     next_kind;
   logic [CW-1:0] next_seq_cnt;

   always_comb
   begin
      next_seq_st  = seq_st;
      next_kind    = kind;
      next_seq_cnt = seq_cnt;
      if (any_evt)
      begin
         next_seq_st = SEQ_HOLD;
         if (por_evt)
         begin
            next_kind    = RK_POR;
            next_seq_cnt = CYC_POR;
         end
         else if (bor_evt)
         begin
            next_kind    = RK_BOR;
            next_seq_cnt = CYC_BOR;
         end
         else
         begin
            next_kind    = RK_SHORT;
            next_seq_cnt = CYC_RST;
         end
      end
      else
      begin
         case (seq_st)
            SEQ_HOLD:
               if (seq_cnt == CW'(1))
                  next_seq_st = SEQ_RUN;
               else
                  next_seq_cnt = seq_cnt - CW'(1);
            default:
               next_seq_cnt = seq_cnt;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seq_st              <= SEQ_HOLD;
         kind                <= RK_POR;
         seq_cnt             <= CYC_POR;
         master_reset_signal <= 1'b1;
      end
      else if (clk_en)
      begin
         seq_st              <= next_seq_st;
         kind                <= next_kind;
         seq_cnt             <= next_seq_cnt;
         master_reset_signal <= (next_seq_st == SEQ_HOLD);
      end
   end

   // ----------------------------------------
   // Clock source choice and start-up delays
   // ----------------------------------------
   logic          boot;
   logic [2:0]    cur_osc;
   rfs_ck_e       ck_st;
   rfs_ck_e       next_ck_st;
   logic [CW-1:0] ck_cnt;
   logic [9:0]    ost_cnt;
   logic          ost_done;
   logic [2:0]    next_src;
   logic          next_ok;

   wire       ck_start = boot | por_evt | bor_evt;
   wire       osc_load = ~cfg.clk_sw_en | ck_start;
   wire [2:0] next_cur_osc = osc_load ? cfg.osc_sel : cur_osc;
   wire       frc_ok  = (ck_cnt >= CYC_FRC);
   wire       rc_ok   = is_frc(cur_osc) ? frc_ok
                      : ((cur_osc == `RFS_OSC_LOW_POWER_INTERNAL_RC) ? (ck_cnt >= CYC_LOW_POWER_INTERNAL_RC) : 1'b1);
   wire       pll_ok  = ~is_pll(cur_osc) | ps.pll_lock;
   wire       ost_ok  = ~is_xtal(cur_osc, cfg.pri_xtal) | ost_done;
   wire       pri_ok  = rc_ok & pll_ok & ost_ok;
   wire       ost_run = (ck_st != CK_IDLE) & is_xtal(cur_osc, cfg.pri_xtal) & ~ost_done;

   always_comb
   begin
      next_ck_st = ck_st;
      next_src   = sys_clk_src;
      next_ok    = sys_clk_ok;
      case (ck_st)
         CK_WAIT:
            if (pri_ok)
            begin
               next_ck_st = CK_IDLE;
               next_src   = cur_osc;
               next_ok    = 1'b1;
            end
            else if (cfg.two_speed & frc_ok)
            begin
               next_ck_st = CK_FRC;
               next_src   = `RFS_OSC_FRC;
               next_ok    = 1'b1;
            end
         CK_FRC:
            if (pri_ok)
            begin
               next_ck_st = CK_IDLE;
               next_src   = cur_osc;
            end
         default:
            next_src = cur_osc;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         boot        <= 1'b1;
         cur_osc     <= `RFS_OSC_FRC;
         ck_st       <= CK_WAIT;
         ck_cnt      <= '0;
         sys_clk_src <= `RFS_OSC_FRC;
         sys_clk_ok  <= 1'b0;
      end
      else if (clk_en)
      begin
         boot    <= 1'b0;
         cur_osc <= next_cur_osc;
         if (ck_start)
         begin
            ck_st      <= CK_WAIT;
            ck_cnt     <= '0;
            sys_clk_ok <= 1'b0;
         end
         else
         begin
            ck_st       <= next_ck_st;
            ck_cnt      <= (ck_cnt == CNT_MAX) ? ck_cnt : ck_cnt + CW'(1);
            sys_clk_src <= next_src;
            sys_clk_ok  <= next_ok;
         end
      end
   end

   // Start-up counter: 1024 oscillator periods
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ost_cnt  <= 10'h000;
         ost_done <= 1'b0;
      end
      else if (clk_en)
      begin
         if (ck_start)
         begin
            ost_cnt  <= 10'h000;
            ost_done <= 1'b0;
         end
         else if (ost_run & osc_tick)
         begin
            ost_cnt  <= ost_cnt + 10'h001;
            ost_done <= (ost_cnt == `RFS_OST_LAST);
         end
      end
   end

   // ----------------------------------------
   // Clock fail monitor start delay
   // ----------------------------------------
   logic [CW-1:0] clock_fail_monitor_cnt;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clock_fail_monitor_cnt    <= '0;
         clock_fail_monitor_active <= 1'b0;
      end
      else if (clk_en)
      begin
         if (master_reset_signal)
         begin
            clock_fail_monitor_cnt    <= '0;
            clock_fail_monitor_active <= 1'b0;
         end
         else if (clock_fail_monitor_cnt != CYC_CLOCK_FAIL_MONITOR)
            clock_fail_monitor_cnt <= clock_fail_monitor_cnt + CW'(1);
         else
            clock_fail_monitor_active <= cfg.clock_fail_monitor_en;
      end
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   logic [31:0] rd_word;
   logic        rd_known;

   always_comb
   begin
      rd_word  = 32'h0000_0000;
      rd_known = 1'b1;
      if (hit(paddr, `RFS_OFF_MAIN_RESET_FLAG_REGISTER))
         rd_word = {16'h0000, main_reset_flag_register};
      else if (hit(paddr, `RFS_OFF_SUP))
         rd_word = {16'h0000, sup};
      else if (hit(paddr, `RFS_OFF_OSC))
         rd_word = {26'h000_0000, clock_fail_monitor_active, ck_st == CK_FRC, sys_clk_ok, cur_osc};
      else if (hit(paddr, `RFS_OFF_CTL))
         rd_word = {31'h0000_0000, deep_sleep_enable};
      else if (hit(paddr, `RFS_OFF_CAL))
         rd_word = {16'h0000, cal};
      else if (hit(paddr, `RFS_OFF_NVM))
         rd_word = {16'h0000, nvm};
      else
         rd_known = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (clk_en)
      begin
         pready  <= setup;
         pslverr <= setup & ~rd_known;
         if (setup)
            prdata <= rd_word;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   logic [CW-1:0] hold_len;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hold_len <= '0;
      else if (clk_en)
         hold_len <= (any_evt | ~master_reset_signal) ? '0 : hold_len + CW'(1);
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn || !clk_en);

   sequence sleep_req;
      evt.power_save_instruction && !evt.power_save_instruction_op && !por_evt;
   endsequence

   sequence sleep_seen;
      main_reset_flag_register[`RFS_B_SLEEP] && (main_reset_flag_register[`RFS_B_DEEP_SLEEP_FLAG] == ($past(deep_sleep_enable) || $past(main_reset_flag_register_wr[`RFS_B_DEEP_SLEEP_FLAG])));
   endsequence

   sup_no_set_a: assert property (((sup & ~$past(sup)) & ~$past(sup_set)) == 16'h0000)
      else $error("supply flag set without hardware cause");
   sup_bor_a: assert property (bor_evt |=> sup[`RFS_B_SUPBOR] && main_reset_flag_register[`RFS_B_BOR])
      else $error("brown-out flags not set");
   por_flags_a: assert property (por_evt |=> sup[`RFS_B_SUPPOR] && main_reset_flag_register == `RFS_MAIN_RESET_FLAG_REGISTER_POR)
      else $error("power-on flag values wrong");
   vb_por_a: assert property (!ps.batt_ok |=> sup[`RFS_B_BATTERY_POWERON_FLAG])
      else $error("battery power-on flag missed");
   vbat_exit_a: assert property (vbat_set |=> sup[`RFS_B_VBAT] && !master_reset_signal)
      else $error("battery exit flag missed");
   wdt_flag_a: assert property (evt.wdt_to && !por_evt |=> main_reset_flag_register[`RFS_B_WATCHDOG_TIMEOUT_FLAG])
      else $error("watchdog flag not set");
   sleep_flag_a: assert property (sleep_req |=> sleep_seen)
      else $error("sleep flags wrong");
   osc_keep_a: assert property (short_evt && cfg.clk_sw_en |=> cur_osc == $past(cur_osc))
      else $error("short reset changed clock source");
   osc_cfg_a: assert property (!cfg.clk_sw_en |=> cur_osc == $past(cfg.osc_sel))
      else $error("clock source not from configuration");
   por_hold_a: assert property ($fell(master_reset_signal) && kind == RK_POR |-> hold_len == CYC_POR)
      else $error("power-on hold length wrong");
   bor_hold_a: assert property ($fell(master_reset_signal) && kind == RK_BOR |-> hold_len == CYC_BOR)
      else $error("brown-out hold length wrong");
   short_hold_a: assert property ($fell(master_reset_signal) && kind == RK_SHORT |-> hold_len == CYC_RST)
      else $error("short reset hold length wrong");
   ost_count_a: assert property ($rose(ost_done) |-> $past(ost_cnt) == `RFS_OST_LAST)
      else $error("start-up counter length wrong");
   ck_parallel_a: assert property (bor_evt |=> master_reset_signal && ck_st == CK_WAIT)
      else $error("clock delay not started with reset");
   clock_fail_monitor_wait_a: assert property ($rose(clock_fail_monitor_active) |-> $past(clock_fail_monitor_cnt) == CYC_CLOCK_FAIL_MONITOR)
      else $error("monitor started early");

endmodule

`default_nettype wire

//--- tb/rfs_pins.sv
// Detector and oscillator stand-in for the reset sequencer
// Assumes the bench raises cmd bits for as long as an event lasts
`timescale 1ns/1ps
`default_nettype none
module rfs_pins
   import rfs_pkg::*;
(
   input  wire logic       pclk, // Bench clock
   input  wire logic [2:0] cmd,  // Pin reset, brown-out, power-on
   output var  rfs_pin_s   pins  // Detector lines
);
   logic [1:0] div = 2'h0;
   // ----------------------------------------
   // Crystal runs free at a quarter of pclk
   // ----------------------------------------
   always @(posedge pclk)
      div <= div + 2'h1;
   assign pins = '{por: cmd[0], bor: cmd[1], batt_ok: 1'b1, ext_rst_n: ~cmd[2], osc_clk: div[1], pll_lock: 1'b1};
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the reset flag sequencer
// Assumes rfs_pins stands for the detectors; clk_en tied high
`timescale 1ns/1ps
`default_nettype none
`include "rfs_regs.svh"
module testbench;
   import rfs_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r = 32'hdc7a_f491;
   logic        pready, pslverr, err, mrs, ok, clock_fail_monitor;
   logic [2:0]  src, cmd = 3'h0;
   rfs_evt_s    evt = '0;
   rfs_cfg_s    cfg = '{`RFS_OSC_FRC, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
   rfs_pin_s    pins;
   int          errors = 0, total_checks = 0, n;
   int          code[7] = '{4, 2, 128, 64, 32, 16, 8};
   int          fbit[7] = '{7, 1, 15, 14, 9, 6, 4};
   always #4 pclk = ~pclk;
   rfs_top #(.TVREG_NS(80)) uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pins(pins), .evt(evt), .cfg(cfg), .master_reset_signal(mrs), .sys_clk_src(src), .sys_clk_ok(ok),
      .clock_fail_monitor_active(clock_fail_monitor));
   rfs_pins partner (.pclk(pclk), .cmd(cmd), .pins(pins));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic len_ok(input int c, input int k);
      int l = `RFS_TRST_US * `RFS_CLK_MHZ + (k < 2 ? 80 * `RFS_CLK_MHZ / 1000 : 0);
      l = l + (k == 0 ? `RFS_POWERON_DELAY_US * `RFS_CLK_MHZ : 0);
      return c >= l - 2 && c <= l + 5;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse(input logic [7:0] e);
      @(posedge pclk);
      evt <= rfs_evt_s'(e);
      @(posedge pclk);
      evt <= '0;
   endtask
   task automatic hold(output int c);
      c = 0;
      while (mrs !== 1'b1 && c < 8)
      begin
         @(posedge pclk);
         c++;
      end
      c = 0;
      do
      begin
         @(posedge pclk);
         c++;
      end
      while (mrs !== 1'b0 && c < 3000);
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      #150000;
      errors++;
      end_of_test;
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      hold(n);
      check(len_ok(n, 0), 1);
      apb(0, `RFS_OFF_MAIN_RESET_FLAG_REGISTER, 0);
      check(rd, 32'h0000_0003);
      repeat (200) @(posedge pclk);
      check({ok, clock_fail_monitor, src}, {2'b11, `RFS_OSC_FRC});
      apb(1, `RFS_OFF_SUP, 32'h0000_0000);
      apb(1, `RFS_OFF_SUP, 32'h0000_000f);
      apb(0, `RFS_OFF_SUP, 0);
      check(rd, 32'h0000_0000);
      foreach (code[i])
      begin
         cmd <= 3'h0;
         apb(1, `RFS_OFF_MAIN_RESET_FLAG_REGISTER, 0);
         if (i < 2)
            cmd <= 3'(code[i]);
         pulse(i < 2 ? 8'h00 : 8'(code[i]));
         hold(n);
         check(len_ok(n, i == 1 ? 1 : 2), 1);
         apb(0, `RFS_OFF_MAIN_RESET_FLAG_REGISTER, 0);
         check(rd, 32'h0000_0001 << fbit[i]);
      end
      cmd <= 3'h0;
      apb(0, `RFS_OFF_SUP, 0);
      check(rd, 32'h0000_0008);
      apb(1, `RFS_OFF_CTL, 32'h0000_0001);
      pulse(8'h02);
      apb(0, `RFS_OFF_MAIN_RESET_FLAG_REGISTER, 0);
      check(rd, 32'h0000_0408);
      pulse(8'h03);
      apb(0, `RFS_OFF_MAIN_RESET_FLAG_REGISTER, 0);
      check(rd, 32'h0000_040c);
      apb(1, `RFS_OFF_MAIN_RESET_FLAG_REGISTER, 32'h0000_0010);
      pulse(8'h04);
      apb(0, `RFS_OFF_MAIN_RESET_FLAG_REGISTER, 0);
      check(rd, 32'h0000_0000);
      repeat (20)
      begin
         r = xs(r);
         apb(1, `RFS_OFF_MAIN_RESET_FLAG_REGISTER, r);
         apb(0, `RFS_OFF_MAIN_RESET_FLAG_REGISTER, 0);
         check(rd, r & 32'h0000_d7ff);
      end
      cfg.osc_sel <= `RFS_OSC_SOSC;
      apb(1, `RFS_OFF_CAL, 32'h0000_1234);
      apb(1, `RFS_OFF_SUP, 32'h0000_0000);
      pulse(8'h10);
      hold(n);
      check(len_ok(n, 2), 1);
      apb(0, `RFS_OFF_CAL, 0);
      check(rd, 32'h0000_1234);
      check(src, `RFS_OSC_FRC);
      cmd <= 3'h1;
      hold(n);
      check(len_ok(n, 0), 1);
      check(ok, 1'b0);
      apb(0, `RFS_OFF_CAL, 0);
      check(rd, 32'h0000_0000);
      apb(0, `RFS_OFF_SUP, 0);
      check(rd, 32'h0000_0005);
      apb(0, `RFS_OFF_MAIN_RESET_FLAG_REGISTER, 0);
      check(rd, 32'h0000_0003);
      apb(0, `RFS_OFF_CTL, 0);
      check(rd, 32'h0000_0000);
      repeat (2700) @(posedge pclk);
      check({ok, src}, {1'b1, `RFS_OSC_SOSC});
      cfg.clk_sw_en <= 1'b0;
      cfg.osc_sel <= `RFS_OSC_LOW_POWER_INTERNAL_RC;
      repeat (2) @(posedge pclk);
      apb(0, `RFS_OFF_OSC, 0);
      check(rd[2:0], `RFS_OSC_LOW_POWER_INTERNAL_RC);
      apb(0, 8'h40, 0);
      check(err, 1'b1);
      check(rd, 32'h0000_0000);
      end_of_test;
   end
endmodule
`default_nettype wire
